// ===== arr_top.sv
// Purpose: Per-source alarm supervision, report scheduling and summary relay
// Assumes: Measurements and acks come from logic on clk_i
// Notes:   Sources 6 and 7 are the login and logout events
//
// Contract
// - Report alarm onset and alarm end
// - Error must persist three seconds first
// - First OK measurement ends alarm at once
// - Minimum minutes between alarms per source
// - Relay opens while masked source alarms
// - Per-source mask gates relay contribution
// - Login and logout never touch relay
// - Test: close 2.5s, open 10s, close 2.5s
// - Transmit enable suppresses only transmission
// - Without ack required, send exactly once
// - Thresholds classify measurement OK or ERROR
// - Need configured count of consecutive errors
// - Retransmit unacknowledged alarm up to maximum
// - Retransmissions spaced by repetition cycle minutes
`timescale 1ns/1ps
`default_nettype none
module arr_top #(
  parameter int unsigned CYC_PER_SEC = arr_pkg::SEC_CYC,
  parameter int unsigned TEST_CLOSE = arr_pkg::TEST_CLOSE_CYC,
  parameter int unsigned TEST_OPEN = arr_pkg::TEST_OPEN_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire arr_pkg::arr_bus_t bus_i,
  output logic [31:0] rdata_o,
  // Measurements
  input wire logic [arr_pkg::NSRC-1:0] meas_valid_i,
  input wire logic [arr_pkg::NSRC-1:0][arr_pkg::MW-1:0] meas_val_i,
  // Reports to the remote_element_manager transport
  output logic report_valid_o,
  output arr_pkg::arr_rpt_t report_o,
  input wire logic report_ready_i,
  // Acknowledgements
  input wire logic ack_i,
  input wire logic [arr_pkg::SW-1:0] ack_src_i,
  // Relay and interrupt
  output logic relay_closed_o,
  output logic irq_o
);
  import arr_pkg::*;

  // ********************************************
  // Functions
  // ********************************************
  function automatic logic is_src_reg(input logic [7:0] a);
    is_src_reg = (a[7:6] == OFS_SRC_REGION);
  endfunction

  function automatic logic [SW-1:0] src_idx(input logic [7:0] a);
    src_idx = a[5:3];
  endfunction

  // ********************************************
  // Declarations
  // ********************************************
  logic [7:0] min_rep_q, retx_max_q, retx_cyc_q;
  logic [NSRC-1:0] tx_en_q, ack_req_q, relay_mask_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q, irq_set;
  logic [31:0] thr_q [NSRC];
  logic [10:0] cnt_cfg_q [NSRC];
  logic test_start_q;
  logic sec_tick, min_tick, tst_active, tst_closed, tst_done;
  logic [7:0] errcnt_q [NSRC];
  logic [7:0] errcnt_d [NSRC];
  logic [1:0] persist_q [NSRC];
  logic [1:0] persist_d [NSRC];
  logic [NSRC-1:0] last_err_q, last_err_d, alarm_q, alarm_d, err_now;
  logic [NSRC-1:0] onset_ev, end_ev;
  logic [NSRC-1:0] pend_q, kind_q, retxf_q, sent_q, wait_q, elig, exhaust;
  logic [7:0] since_q [NSRC];
  logic [7:0] retry_q [NSRC];
  logic [7:0] retx_cnt_q [NSRC];
  logic grant_vld;
  logic [SW-1:0] grant;
  logic [31:0] rd_d;

  // ********************************************
  // Timebase and relay test
  // ********************************************
  arr_timebase #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_tb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sec_tick_o(sec_tick),
    .min_tick_o(min_tick)
  );

  arr_relay_test #(
    .CLOSE_CYC(TEST_CLOSE),
    .OPEN_CYC(TEST_OPEN)
  ) u_tst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(test_start_q),
    .active_o(tst_active),
    .closed_o(tst_closed),
    .done_o(tst_done)
  );

  // ********************************************
  // Register writes
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      min_rep_q <= RST_MIN_REP;
      retx_max_q <= RST_RETX_MAX;
      retx_cyc_q <= RST_RETX_CYC;
      tx_en_q <= RST_ALL_SRC;
      ack_req_q <= RST_ALL_SRC;
      relay_mask_q <= RST_ALL_SRC;
      irq_en_q <= '0;
      test_start_q <= 1'b0;
    end else begin
      test_start_q <= bus_i.we && bus_i.addr == OFS_CTRL &&
                      bus_i.wdata[CTRL_TEST_BIT];
      if (bus_i.we) begin
        unique case (bus_i.addr)
          OFS_MIN_REP: min_rep_q <= bus_i.wdata[7:0];
          OFS_RETX_MAX: retx_max_q <= bus_i.wdata[7:0];
          OFS_RETX_CYC: retx_cyc_q <= bus_i.wdata[7:0];
          OFS_TX_EN: tx_en_q <= bus_i.wdata[NSRC-1:0];
          OFS_ACK_REQ: ack_req_q <= bus_i.wdata[NSRC-1:0];
          OFS_RELAY_MASK: relay_mask_q <= bus_i.wdata[NSRC-1:0];
          OFS_IRQ_EN: irq_en_q <= bus_i.wdata[IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Per-source thresholds and count words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NSRC; i++) begin
        thr_q[i] <= RST_THR;
        cnt_cfg_q[i] <= RST_CNT;
      end
    end else if (bus_i.we && is_src_reg(bus_i.addr)) begin
      if (bus_i.addr[2]) begin
        cnt_cfg_q[src_idx(bus_i.addr)] <= bus_i.wdata[10:0];
      end else begin
        thr_q[src_idx(bus_i.addr)] <= bus_i.wdata;
      end
    end
  end

  // ********************************************
  // Register reads, data one cycle later
  // ********************************************
  always_comb begin
    rd_d = 32'h0;
    if (is_src_reg(bus_i.addr)) begin
      rd_d = bus_i.addr[2] ? {21'h0, cnt_cfg_q[src_idx(bus_i.addr)]}
                           : thr_q[src_idx(bus_i.addr)];
    end else begin
      unique case (bus_i.addr)
        OFS_CTRL: rd_d = {31'h0, tst_active};
        OFS_MIN_REP: rd_d = {24'h0, min_rep_q};
        OFS_RETX_MAX: rd_d = {24'h0, retx_max_q};
        OFS_RETX_CYC: rd_d = {24'h0, retx_cyc_q};
        OFS_TX_EN: rd_d = {24'h0, tx_en_q};
        OFS_ACK_REQ: rd_d = {24'h0, ack_req_q};
        OFS_RELAY_MASK: rd_d = {24'h0, relay_mask_q};
        OFS_STATE: rd_d = {16'h0, wait_q, alarm_q};
        OFS_IRQ_STAT: rd_d = {28'h0, irq_stat_q};
        OFS_IRQ_EN: rd_d = {28'h0, irq_en_q};
        default: rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else begin
      rdata_o <= bus_i.re ? rd_d : 32'h0;
    end
  end

  // ********************************************
  // Measurement classification and debounce
  // ********************************************
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      // Below lower or above upper threshold is an error
      err_now[i] = (cnt_cfg_q[i][CNT_LOW_EN_BIT] &&
                    meas_val_i[i] < thr_q[i][15:0]) ||
                   (cnt_cfg_q[i][CNT_UP_EN_BIT] &&
                    meas_val_i[i] > thr_q[i][31:16]);
      errcnt_d[i] = errcnt_q[i];
      persist_d[i] = persist_q[i];
      last_err_d[i] = last_err_q[i];
      if (meas_valid_i[i]) begin
        last_err_d[i] = err_now[i];
        if (!err_now[i]) begin
          errcnt_d[i] = 8'h0;
        end else if (errcnt_q[i] != 8'hFF) begin
          errcnt_d[i] = errcnt_q[i] + 8'h1;
        end
      end
      // Seconds of continuous error, restarted on a fresh error run
      if (meas_valid_i[i] && (!err_now[i] || !last_err_q[i])) begin
        persist_d[i] = 2'h0;
      end else if (last_err_q[i] && sec_tick && persist_q[i] != PERSIST_S) begin
        persist_d[i] = persist_q[i] + 2'h1;
      end
      alarm_d[i] = alarm_q[i];
      if (meas_valid_i[i] && !err_now[i]) begin
        alarm_d[i] = 1'b0;
      end else if (!alarm_q[i] && last_err_d[i] &&
                   errcnt_d[i] >= cnt_cfg_q[i][7:0] && errcnt_d[i] != 8'h0 &&
                   (!cnt_cfg_q[i][CNT_PERSIST_BIT] ||
                    persist_d[i] == PERSIST_S)) begin
        alarm_d[i] = 1'b1;
      end
    end
  end

  assign onset_ev = alarm_d & ~alarm_q;
  assign end_ev = alarm_q & ~alarm_d;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NSRC; i++) begin
        errcnt_q[i] <= 8'h0;
        persist_q[i] <= 2'h0;
      end
      last_err_q <= '0;
      alarm_q <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        errcnt_q[i] <= errcnt_d[i];
        persist_q[i] <= persist_d[i];
      end
      last_err_q <= last_err_d;
      alarm_q <= alarm_d;
    end
  end

  // ********************************************
  // Report arbitration, lowest source first
  // ********************************************
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      elig[i] = pend_q[i] && (!kind_q[i] || retxf_q[i] ||
                              since_q[i] >= min_rep_q);
    end
    grant_vld = 1'b0;
    grant = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (elig[i]) begin
        grant_vld = !report_valid_o || report_ready_i;
        grant = SW'(i);
      end
    end
  end

  // Report output register, held until the transport takes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      report_valid_o <= 1'b0;
      report_o <= '0;
    end else begin
      if (report_ready_i) begin
        report_valid_o <= 1'b0;
      end
      if (grant_vld && tx_en_q[grant]) begin
        report_valid_o <= 1'b1;
        report_o.src <= grant;
        report_o.onset <= kind_q[grant];
        report_o.retx <= retxf_q[grant];
      end
    end
  end

  // ********************************************
  // Per-source report state
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
      kind_q <= '0;
      retxf_q <= '0;
      sent_q <= '0;
      wait_q <= '0;
      exhaust <= '0;
      for (int i = 0; i < NSRC; i++) begin
        since_q[i] <= 8'hFF;
        retry_q[i] <= 8'h0;
        retx_cnt_q[i] <= 8'h0;
      end
    end else begin
      exhaust <= '0;
      for (int i = 0; i < NSRC; i++) begin
        if (min_tick && since_q[i] != 8'hFF) begin
          since_q[i] <= since_q[i] + 8'h1;
        end
        if (min_tick && wait_q[i]) begin
          retry_q[i] <= retry_q[i] + 8'h1;
          if (retry_q[i] + 8'h1 >= retx_cyc_q) begin
            wait_q[i] <= 1'b0;
            if (retx_cnt_q[i] < retx_max_q) begin
              pend_q[i] <= 1'b1;
              kind_q[i] <= 1'b1;
              retxf_q[i] <= 1'b1;
              retx_cnt_q[i] <= retx_cnt_q[i] + 8'h1;
            end else begin
              exhaust[i] <= 1'b1;
            end
          end
        end
        if (ack_i && ack_src_i == SW'(i)) begin
          wait_q[i] <= 1'b0;
        end
        // Dispatch: a disabled source is consumed without sending
        if (grant_vld && grant == SW'(i)) begin
          pend_q[i] <= 1'b0;
          retry_q[i] <= 8'h0;
          if (kind_q[i]) begin
            sent_q[i] <= 1'b1;
            wait_q[i] <= ack_req_q[i] && tx_en_q[i];
            if (!retxf_q[i]) begin
              since_q[i] <= 8'h0;
              retx_cnt_q[i] <= 8'h0;
            end
          end
        end
        if (onset_ev[i]) begin
          pend_q[i] <= 1'b1;
          kind_q[i] <= 1'b1;
          retxf_q[i] <= 1'b0;
          sent_q[i] <= 1'b0;
        end else if (end_ev[i]) begin
          // End reported only once its onset went out
          pend_q[i] <= sent_q[i] || (grant_vld && grant == SW'(i));
          kind_q[i] <= 1'b0;
          retxf_q[i] <= 1'b0;
          wait_q[i] <= 1'b0;
        end
      end
    end
  end

  // ********************************************
  // Summary relay
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_closed_o <= 1'b1;
    end else if (tst_active) begin
      relay_closed_o <= tst_closed;
    end else begin
      // Open while any masked non-login source alarms
      relay_closed_o <= ~|(alarm_q & relay_mask_q & ~LOGIN_SRC_MASK);
    end
  end

  // ********************************************
  // Interrupts; a new event beats a clear
  // ********************************************
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_ONSET] = |onset_ev;
    irq_set[IRQ_END] = |end_ev;
    irq_set[IRQ_TEST_DONE] = tst_done;
    irq_set[IRQ_RETX_OUT] = |exhaust;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_o <= 1'b0;
    end else begin
      if (bus_i.we && bus_i.addr == OFS_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~bus_i.wdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end
endmodule // arr_top
`default_nettype wire

// ===== arr_pkg.sv
// Purpose: Shared constants and types for the alarm report and relay block
// Assumes: 200 MHz system clock, eight alarm sources
// Notes:   Offsets are byte addresses on the plain register port
package arr_pkg;

  // ********************************************
  // Sizes
  // ********************************************
  localparam int NSRC = 8;
  localparam int SW = 3;
  localparam int MW = 16;

  // ********************************************
  // Timing
  // ********************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SEC_S = 1;
  localparam int unsigned SEC_CYC = CLK_HZ * SEC_S;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam logic [1:0] PERSIST_S = 2'h3;
  localparam int unsigned TEST_CLOSE_MS = 2500;
  localparam int unsigned TEST_OPEN_MS = 10000;
  localparam int unsigned TEST_CLOSE_CYC = (CLK_HZ / 1000) * TEST_CLOSE_MS;
  localparam int unsigned TEST_OPEN_CYC = (CLK_HZ / 1000) * TEST_OPEN_MS;

  // ********************************************
  // Register offsets
  // ********************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MIN_REP = 8'h04;
  localparam logic [7:0] OFS_RETX_MAX = 8'h08;
  localparam logic [7:0] OFS_RETX_CYC = 8'h0C;
  localparam logic [7:0] OFS_TX_EN = 8'h10;
  localparam logic [7:0] OFS_ACK_REQ = 8'h14;
  localparam logic [7:0] OFS_RELAY_MASK = 8'h18;
  localparam logic [7:0] OFS_STATE = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN = 8'h28;
  localparam logic [1:0] OFS_SRC_REGION = 2'h1;
  localparam int CTRL_TEST_BIT = 0;

  // ********************************************
  // Field positions of per-source count word
  // ********************************************
  localparam int CNT_PERSIST_BIT = 8;
  localparam int CNT_LOW_EN_BIT = 9;
  localparam int CNT_UP_EN_BIT = 10;

  // ********************************************
  // Reset values
  // ********************************************
  localparam logic [7:0] RST_MIN_REP = 8'h03;
  localparam logic [7:0] RST_RETX_MAX = 8'h03;
  localparam logic [7:0] RST_RETX_CYC = 8'h0A;
  localparam logic [NSRC-1:0] RST_ALL_SRC = 8'hFF;
  localparam logic [31:0] RST_THR = 32'hFFFF_0000;
  localparam logic [10:0] RST_CNT = 11'h103;
  localparam logic [NSRC-1:0] LOGIN_SRC_MASK = 8'hC0;

  // ********************************************
  // Interrupt bits
  // ********************************************
  localparam int IRQ_W = 4;
  localparam int IRQ_ONSET = 0;
  localparam int IRQ_END = 1;
  localparam int IRQ_TEST_DONE = 2;
  localparam int IRQ_RETX_OUT = 3;

  // ********************************************
  // Carriers
  // ********************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } arr_bus_t;

  typedef struct packed {
    logic [SW-1:0] src;
    logic onset;
    logic retx;
  } arr_rpt_t;

endpackage : arr_pkg

// ===== arr_timebase.sv
// Purpose: Second and minute ticks from the system clock
// Assumes: Synchronous active-high reset
// Notes:   Ticks are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module arr_timebase #(
  parameter int unsigned CYC_PER_SEC = arr_pkg::SEC_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Ticks
  output logic sec_tick_o,
  output logic min_tick_o
);
  import arr_pkg::*;

  logic [31:0] cyc_q;
  logic [5:0] sec_q;

  // ********************************************
  // Cycle and second counters
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_q <= 32'h0;
      sec_q <= 6'h0;
      sec_tick_o <= 1'b0;
      min_tick_o <= 1'b0;
    end else begin
      sec_tick_o <= 1'b0;
      min_tick_o <= 1'b0;
      if (cyc_q == CYC_PER_SEC - 1) begin
        cyc_q <= 32'h0;
        sec_tick_o <= 1'b1;
        if (sec_q == 6'(SEC_PER_MIN - 1)) begin
          sec_q <= 6'h0;
          min_tick_o <= 1'b1;
        end else begin
          sec_q <= sec_q + 6'h1;
        end
      end else begin
        cyc_q <= cyc_q + 32'h1;
      end
    end
  end
endmodule // arr_timebase
`default_nettype wire

// ===== arr_relay_test.sv
// Purpose: Timed relay test sequence, closed-open-closed
// Assumes: Start is a one-cycle pulse; ignored while running
// Notes:   closed_o is meaningful only while active_o is high
`timescale 1ns/1ps
`default_nettype none
module arr_relay_test #(
  parameter int unsigned CLOSE_CYC = arr_pkg::TEST_CLOSE_CYC,
  parameter int unsigned OPEN_CYC = arr_pkg::TEST_OPEN_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  // Status
  output logic active_o,
  output logic closed_o,
  output logic done_o
);
  import arr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CLOSE1, ST_OPEN, ST_CLOSE2} arr_tst_t;
  arr_tst_t st_q;
  logic [31:0] cnt_q;

  // ********************************************
  // Sequence: close, open, close, then back
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 32'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      cnt_q <= cnt_q + 32'h1;
      unique case (st_q)
        ST_IDLE: begin
          cnt_q <= 32'h0;
          if (start_i) begin
            st_q <= ST_CLOSE1;
          end
        end
        ST_CLOSE1: begin
          if (cnt_q == CLOSE_CYC - 1) begin
            st_q <= ST_OPEN;
            cnt_q <= 32'h0;
          end
        end
        ST_OPEN: begin
          if (cnt_q == OPEN_CYC - 1) begin
            st_q <= ST_CLOSE2;
            cnt_q <= 32'h0;
          end
        end
        ST_CLOSE2: begin
          if (cnt_q == CLOSE_CYC - 1) begin
            st_q <= ST_IDLE;
            done_o <= 1'b1;
          end
        end
      endcase
    end
  end

  assign active_o = (st_q != ST_IDLE);
  assign closed_o = (st_q != ST_OPEN);
endmodule // arr_relay_test
`default_nettype wire

// ===== arr_top_sva.sv
// Purpose: Port assertions for arr_top
// Assumes: Settings shadowed from writes
// Notes:   Relay test judged by phase lengths
`timescale 1ns/1ps
`default_nettype none
module arr_top_sva #(
  parameter int unsigned TEST_CLOSE = 5,
  parameter int unsigned TEST_OPEN = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire arr_pkg::arr_bus_t bus_i,
  input wire logic [31:0] rdata_o,
  input wire logic report_valid_o,
  input wire arr_pkg::arr_rpt_t report_o,
  input wire logic report_ready_i,
  input wire logic relay_closed_o
);
  import arr_pkg::*;
  logic [7:0] txen_q, ackrq_q, rmax_q;
  logic [7:0] rcnt_q [NSRC];
  logic tst_q;
  int open_q, close_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ********************************************
  // Helper state
  // ********************************************
  // Shadow of settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txen_q <= RST_ALL_SRC;
      ackrq_q <= RST_ALL_SRC;
      rmax_q <= RST_RETX_MAX;
    end else if (bus_i.we) begin
      if (bus_i.addr == OFS_TX_EN) txen_q <= bus_i.wdata[7:0];
      if (bus_i.addr == OFS_ACK_REQ) ackrq_q <= bus_i.wdata[7:0];
      if (bus_i.addr == OFS_RETX_MAX) rmax_q <= bus_i.wdata[7:0];
    end
  end
  // Resends taken per source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NSRC; k++) rcnt_q[k] <= 8'h00;
    end else if (report_valid_o && report_ready_i) begin
      rcnt_q[report_o.src] <= report_o.retx ?
        rcnt_q[report_o.src] + 8'h01 : 8'h00;
    end
  end
  // Test window from a start write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tst_q <= 1'b0;
      close_q <= 0;
    end else if (bus_i.we && bus_i.addr == OFS_CTRL && relay_closed_o &&
                 bus_i.wdata[CTRL_TEST_BIT] && !tst_q) begin
      tst_q <= 1'b1;
      close_q <= 0;
    end else begin
      if ($rose(relay_closed_o)) tst_q <= 1'b0;
      close_q <= relay_closed_o ? close_q + 1 : 0;
    end
  end
  // Open stretch length
  always_ff @(posedge clk_i) begin
    open_q <= relay_closed_o ? 0 : open_q + 1;
  end
  // ********************************************
  // Assertions
  // ********************************************
  AST_RPT_HOLD: assert property (
    report_valid_o && !report_ready_i |=> report_valid_o && $stable(report_o))
    else $error("report dropped");
  AST_END_PLAIN: assert property (
    report_valid_o && !report_o.onset |-> !report_o.retx)
    else $error("end flagged resend");
  AST_TX_OFF: assert property (
    report_valid_o |-> txen_q[report_o.src])
    else $error("report while tx off");
  AST_ACK_OFF: assert property (
    report_valid_o && report_o.retx |-> ackrq_q[report_o.src])
    else $error("resend without ack");
  AST_RETX_LIMIT: assert property (
    report_valid_o && report_o.retx |-> rcnt_q[report_o.src] < rmax_q)
    else $error("too many resends");
  AST_TEST_OPEN: assert property (
    $rose(relay_closed_o) && tst_q |-> open_q == TEST_OPEN)
    else $error("test open length");
  AST_TEST_CLOSE: assert property (
    $fell(relay_closed_o) && tst_q |->
      close_q >= TEST_CLOSE && close_q <= TEST_CLOSE + 4)
    else $error("test close length");
  AST_RDATA_IDLE: assert property (
    !$past(bus_i.re) |-> rdata_o == 32'h0)
    else $error("stray read data");
endmodule // arr_top_sva
bind arr_top arr_top_sva #(.TEST_CLOSE(TEST_CLOSE), .TEST_OPEN(TEST_OPEN))
  i_sva (.clk_i, .rst_i, .bus_i, .rdata_o, .report_valid_o, .report_o,
  .report_ready_i, .relay_closed_o);
`default_nettype wire

// ===== arr_rem_model.sv
// Purpose: Remote manager transport model
// Assumes: Bench sets stall and ack
// Notes:   Ack source toggles when idle
`timescale 1ns/1ps
`default_nettype none
module arr_rem_model (
  // Clock, reset and behaviour
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] stall_i,
  input wire logic ack_en_i,
  // Report handshake and ack
  input wire logic valid_i,
  input wire arr_pkg::arr_rpt_t rpt_i,
  output logic ready_o,
  output logic ack_o,
  output logic [2:0] ack_src_o
);
  import arr_pkg::*;
  logic [3:0] cnt_q;
  // Take after stall, ack onsets if enabled
  always_ff @(posedge clk_i) begin
    ack_o <= 1'b0;
    ack_src_o <= ~ack_src_o;
    if (rst_i) begin
      ready_o <= 1'b0;
      cnt_q <= 4'h0;
      ack_src_o <= 3'h0;
    end else if (ready_o && valid_i) begin
      ready_o <= 1'b0;
      cnt_q <= 4'h0;
      ack_o <= ack_en_i && rpt_i.onset;
      ack_src_o <= rpt_i.src;
    end else begin
      ready_o <= valid_i && cnt_q >= stall_i;
      cnt_q <= valid_i ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule // arr_rem_model
`default_nettype wire

// ===== arr_tb.sv
// Purpose: Self-checking bench for arr_top
// Assumes: Short second of ten cycles
// Notes:   Reads and reports checked against queues
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); \
  end \
end
module testbench;
  import arr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  arr_bus_t bus_i = '0;
  logic [31:0] rdata_o;
  logic [31:0] rnd = 32'h8ED4;
  logic [NSRC-1:0] meas_valid_i = '0;
  logic [NSRC-1:0][MW-1:0] meas_val_i = '0;
  logic report_valid_o, report_ready_i, ack_i, relay_closed_o, irq_o;
  logic ack_en = 1'b1, rd_p = 1'b0;
  logic [SW-1:0] ack_src_i;
  logic [3:0] stall = 4'h0;
  arr_rpt_t report_o;
  arr_rpt_t rpt_q[$];
  logic [31:0] rd_q[$];
  int err_count = 0, tests_run = 0;
  int i, n;
  // System clock
  always #2.5 clk_i = ~clk_i;
  arr_top #(.CYC_PER_SEC(10), .TEST_CLOSE(5), .TEST_OPEN(20)) i_dut (
    .clk_i, .rst_i, .bus_i, .rdata_o, .meas_valid_i, .meas_val_i,
    .report_valid_o, .report_o, .report_ready_i, .ack_i, .ack_src_i,
    .relay_closed_o, .irq_o);
  arr_rem_model i_rem (
    .clk_i, .rst_i, .stall_i(stall), .ack_en_i(ack_en),
    .valid_i(report_valid_o), .rpt_i(report_o), .ready_o(report_ready_i),
    .ack_o(ack_i), .ack_src_o(ack_src_i));
  // Check reads and reports against oldest notes
  always @(posedge clk_i) begin : mon
    logic [31:0] ew;
    arr_rpt_t er;
    if (rd_p) begin
      ew = rd_q.pop_front();
      `CHK("rdata", ew, rdata_o)
    end
    rd_p = bus_i.re;
    if (report_valid_o && report_ready_i) begin
      er = (rpt_q.size() > 0) ? rpt_q.pop_front() : 'x;
      `CHK("report", er, report_o)
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_i <= '{a, d, 1'b1, 1'b0};
    tick(1);
    bus_i.we <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus_i <= '{a, rnd, 1'b0, 1'b1};
    tick(1);
    bus_i.re <= 1'b0;
    tick(2);
  endtask
  // Measure: 0 at limit, 1 above, 2 below
  task automatic ms(input int s, input int m, input logic rep);
    rnd = xs(rnd);
    meas_val_i[s] <= m == 0 ? 16'h0100 :
      m == 1 ? 16'h0101 + rnd[7:0] : {8'h00, rnd[7:0]};
    meas_valid_i <= 8'h01 << s;
    tick(1);
    meas_valid_i <= 8'h00;
    if (rep) rpt_q.push_back('{src: s[2:0], onset: m != 0, retx: 1'b0});
    tick(1);
  endtask
  // Limits 0x100; c: upper, lower, persist enables
  task automatic cfg(input int s, input logic [7:0] c8, input logic [2:0] c);
    wr(8'h40 + 8'(s * 8), 32'h0100_0100);
    wr(8'h44 + 8'(s * 8), {21'h0, c, c8});
  endtask
  task automatic rly(input logic e);
    tick(1);
    `CHK("relay", e, relay_closed_o)
  endtask
  task automatic drain(input int c);
    for (int k = 0; k < c && rpt_q.size() > 0; k++) tick(1);
    `CHK("reports", 32'd0, 32'(rpt_q.size()))
    if (rpt_q.size() > 0) print_verdict();
  endtask
  // Main sequence
  initial begin
    tick(4);
    rst_i <= 1'b0;
    rly(1'b1);
    rd(OFS_MIN_REP, 32'h3);
    rd(OFS_RETX_CYC, 32'hA);
    rd(OFS_ACK_REQ, 32'hFF);
    rd(8'h30, 32'h0);
    wr(OFS_IRQ_EN, 32'h1);
    cfg(0, 8'h2, 3'b100);
    ms(0, 1, 0);
    ms(0, 0, 0);
    ms(0, 1, 0);
    rly(1'b1);
    ms(0, 1, 1);
    rly(1'b0);
    `CHK("irq", 1'b1, irq_o)
    wr(OFS_IRQ_CLR, 32'hF);
    tick(1);
    `CHK("irq", 1'b0, irq_o)
    ms(0, 0, 1);
    rly(1'b1);
    drain(50);
    rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_RELAY_MASK, 32'hFD);
    cfg(1, 8'h1, 3'b010);
    ms(1, 2, 1);
    rly(1'b1);
    wr(OFS_RELAY_MASK, 32'hFF);
    rly(1'b0);
    ms(1, 0, 1);
    cfg(6, 8'h1, 3'b100);
    ms(6, 1, 1);
    rly(1'b1);
    ms(6, 0, 1);
    drain(50);
    wr(OFS_TX_EN, 32'hF7);
    cfg(3, 8'h1, 3'b100);
    ms(3, 1, 0);
    rly(1'b0);
    rd(OFS_STATE, 32'h8);
    ms(3, 0, 0);
    wr(OFS_TX_EN, 32'hFF);
    cfg(2, 8'h1, 3'b101);
    for (i = 0; i < 12; i++) begin
      ms(2, 1, i == 0);
      tick(3);
      if (i == 1) rly(1'b1);
    end
    rly(1'b0);
    ms(2, 0, 1);
    drain(50);
    ack_en <= 1'b0;
    wr(OFS_ACK_REQ, 32'hDF);
    wr(OFS_RETX_CYC, 32'h1);
    cfg(5, 8'h1, 3'b100);
    ms(5, 1, 1);
    drain(50);
    ms(5, 0, 1);
    drain(50);
    ms(5, 1, 1);
    tick(900);
    `CHK("held", 32'd1, 32'(rpt_q.size()))
    drain(1500);
    tick(1500);
    ms(5, 0, 1);
    wr(OFS_ACK_REQ, 32'hFF);
    wr(OFS_RETX_MAX, 32'h1);
    wr(OFS_IRQ_CLR, 32'hF);
    stall <= {2'b00, rnd[1:0]} + 4'h1;
    cfg(4, 8'h1, 3'b100);
    ms(4, 1, 1);
    rpt_q.push_back('{src: 3'h4, onset: 1'b1, retx: 1'b1});
    drain(1500);
    tick(1500);
    rd(OFS_IRQ_STAT, 32'h9);
    ms(4, 0, 1);
    drain(50);
    wr(OFS_CTRL, 32'h1);
    n = 0;
    for (i = 0; i < 45; i++) begin
      tick(1);
      if (relay_closed_o !== 1'b1) n++;
    end
    `CHK("open", 32'd20, 32'(n))
    rd(OFS_CTRL, 32'h0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
